/* File: core/encoder_probe_pkg.sv */
// Constants for the encoder control word interpreter.
// Assumes one clock domain; every user writes encoder_probe_pkg::name.
package encoder_probe_pkg;

	////////////////////////////////////////////////////////////////////////
	// Control word layout
	localparam int CTRL_WIDTH = 16;
	localparam int FUNC_COUNT = 4;
	localparam int FUNC_LSB = 0;
	localparam int CMD_LSB = 4;
	localparam int CMD_WIDTH = 3;
	localparam int MODE_BIT = 7;

	////////////////////////////////////////////////////////////////////////
	// Command and mode encodings
	localparam logic [CMD_WIDTH-1:0] CMD_NONE = 3'h0;
	localparam logic [CMD_WIDTH-1:0] CMD_ACTIVATE = 3'h1;
	localparam logic MODE_REFMARK = 1'b0;
	localparam logic MODE_PROBE = 1'b1;

	////////////////////////////////////////////////////////////////////////
	// Reset values, mark counter width and limit
	localparam logic MODE_RESET = 1'b0;
	localparam int MARK_COUNT_WIDTH = 3;
	localparam logic [MARK_COUNT_WIDTH-1:0] MARK_COUNT_RESET = 3'h0;
	localparam logic [MARK_COUNT_WIDTH-1:0] MARK_COUNT_MAX = 3'h4;

	////////////////////////////////////////////////////////////////////////
	// Capture channel states
	typedef enum logic [2:0] {
		CH_IDLE = 3'b001,
		CH_ARMED = 3'b010,
		CH_DONE = 3'b100
	} channel_state_t;

endpackage

/* File: core/capture_channel_if.sv */
// Signals between the control word interpreter and one capture channel.
// Assumes the channel and its controller share one clock.
`timescale 1ns/100ps
`default_nettype none
interface capture_channel_if #(parameter int POS_WIDTH = 32);
	logic arm;
	logic hit;
	logic [POS_WIDTH-1:0] position;
	logic active;
	logic done;
	logic [POS_WIDTH-1:0] value;

	modport ctrl (output arm, output hit, output position, input active, input done, input value);
	modport chan (input arm, input hit, input position, output active, output done, output value);
endinterface
`default_nettype wire

/* File: core/capture_channel.sv */
// One capture function: armed by a start, latches the position on its event.
// Assumes arm, hit and position are synchronous to clk_in.
`timescale 1ns/100ps
`default_nettype none
module capture_channel (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic clk_en_in,
	capture_channel_if.chan link
);

	encoder_probe_pkg::channel_state_t state;

	////////////////////////////////////////////////////////////////////////
	// Arm, wait for the event, hold the result
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			state <= encoder_probe_pkg::CH_IDLE;
		end else if (clk_en_in) begin
			case (state)
				encoder_probe_pkg::CH_IDLE: begin
					if (link.arm) begin
						state <= encoder_probe_pkg::CH_ARMED;
					end
				end
				encoder_probe_pkg::CH_ARMED: begin
					// A new start on the same edge wins; the event is dropped
					if (link.hit && !link.arm) begin
						state <= encoder_probe_pkg::CH_DONE;
					end
				end
				encoder_probe_pkg::CH_DONE: begin
					if (link.arm) begin
						state <= encoder_probe_pkg::CH_ARMED;
					end
				end
				default: begin
					state <= encoder_probe_pkg::CH_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			link.value <= '0;
		end else if (clk_en_in && state == encoder_probe_pkg::CH_ARMED && link.hit && !link.arm) begin
			link.value <= link.position;
		end
	end

	assign link.active = (state == encoder_probe_pkg::CH_ARMED);
	assign link.done = (state == encoder_probe_pkg::CH_DONE);

	////////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_armed_hit;
		clk_en_in && link.active && link.hit && !link.arm;
	endsequence

	a_capture_on_hit: assert property (@(posedge clk_in) disable iff (reset_in)
		s_armed_hit |=> link.done && !link.active && link.value == $past(link.position))
		else $error("capture did not latch position on its event");

	a_arm_starts_wait: assert property (@(posedge clk_in) disable iff (reset_in)
		(clk_en_in && !link.active && link.arm) |=> link.active && !link.done)
		else $error("arm did not start the function");

	a_wait_holds: assert property (@(posedge clk_in) disable iff (reset_in)
		(link.active && !(clk_en_in && link.hit && !link.arm)) |=> link.active)
		else $error("armed function ended without its event");

endmodule
`default_nettype wire

/* File: core/encoder_probe_refmark_control.sv */
// Encoder control word interpreter: reference mark search and flying measurement.
// Assumes control word, probe, mark and position inputs are synchronous to clk_in.
`timescale 1ns/100ps
`default_nettype none
module encoder_probe_refmark_control #(
	parameter int POS_WIDTH = 32
) (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic clk_en_in,
	input wire logic [encoder_probe_pkg::CTRL_WIDTH-1:0] encoder_control_word_in,
	input wire logic control_valid_in,
	input wire logic ref_mark_in,
	input wire logic probe1_in,
	input wire logic probe2_in,
	input wire logic [POS_WIDTH-1:0] position_in,
	input wire logic [1:0] value_select_in,
	output logic [encoder_probe_pkg::FUNC_COUNT-1:0] function_status_bits_out,
	output logic mode_out,
	output logic values_ready_out,
	output logic [POS_WIDTH-1:0] value_out
);

	localparam int FUNCS = encoder_probe_pkg::FUNC_COUNT;
	localparam int MCW = encoder_probe_pkg::MARK_COUNT_WIDTH;

	if (POS_WIDTH < 1 || POS_WIDTH > 64) begin : gen_bad_width
		$error("POS_WIDTH must lie between 1 and 64");
	end

	////////////////////////////////////////////////////////////////////////
	// Control word fields
	logic [FUNCS-1:0] func_bits;
	logic [encoder_probe_pkg::CMD_WIDTH-1:0] command;
	logic word_mode;
	logic start;

	assign func_bits = encoder_control_word_in[encoder_probe_pkg::FUNC_LSB +: FUNCS];
	assign command = encoder_control_word_in[encoder_probe_pkg::CMD_LSB +: encoder_probe_pkg::CMD_WIDTH];
	assign word_mode = encoder_control_word_in[encoder_probe_pkg::MODE_BIT];
	assign start = control_valid_in && command == encoder_probe_pkg::CMD_ACTIVATE;

	logic mode;

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			mode <= encoder_probe_pkg::MODE_RESET;
		end else if (clk_en_in && start) begin
			mode <= word_mode;
		end
	end

	assign mode_out = mode;

	////////////////////////////////////////////////////////////////////////
	// Edge detection on probes and reference mark
	logic probe1_last;
	logic probe2_last;
	logic ref_last;

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			probe1_last <= 1'b0;
			probe2_last <= 1'b0;
			ref_last <= 1'b0;
		end else if (clk_en_in) begin
			probe1_last <= probe1_in;
			probe2_last <= probe2_in;
			ref_last <= ref_mark_in;
		end
	end

	logic ref_rise;
	logic [FUNCS-1:0] probe_hit;

	assign ref_rise = ref_mark_in && !ref_last;
	assign probe_hit = {!probe2_in && probe2_last, probe2_in && !probe2_last,
		!probe1_in && probe1_last, probe1_in && !probe1_last};

	// Marks seen since the last start, saturating at MARK_COUNT_MAX; in reference mark mode mark n completes function n
	logic [encoder_probe_pkg::MARK_COUNT_WIDTH-1:0] mark_count;

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			mark_count <= encoder_probe_pkg::MARK_COUNT_RESET;
		end else if (clk_en_in) begin
			if (start) begin
				mark_count <= encoder_probe_pkg::MARK_COUNT_RESET;
			end else if (ref_rise && mark_count != encoder_probe_pkg::MARK_COUNT_MAX) begin
				mark_count <= mark_count + 3'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Capture channels, one per function
	capture_channel_if #(.POS_WIDTH(POS_WIDTH)) chan_if[FUNCS] ();
	logic [FUNCS-1:0] act;
	logic [FUNCS-1:0] dn;
	logic [FUNCS-1:0] ref_hit;
	logic [POS_WIDTH-1:0] values [FUNCS];

	genvar g;
	generate
		for (g = 0; g < FUNCS; g++) begin : gen_chan
			assign ref_hit[g] = ref_rise && mark_count == MCW'(g);
			assign chan_if[g].arm = start && func_bits[g];
			assign chan_if[g].hit = (mode == encoder_probe_pkg::MODE_PROBE) ? probe_hit[g] : ref_hit[g];
			assign chan_if[g].position = position_in;
			assign act[g] = chan_if[g].active;
			assign dn[g] = chan_if[g].done;
			assign values[g] = chan_if[g].value;

			capture_channel u_chan (
				.clk_in(clk_in),
				.reset_in(reset_in),
				.clk_en_in(clk_en_in),
				.link(chan_if[g])
			);
		end
	endgenerate

	assign function_status_bits_out = act;

	////////////////////////////////////////////////////////////////////////
	// Read-back: held at zero while any activated function still runs
	logic next_ready;

	assign next_ready = (|dn) && !(|act);

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			values_ready_out <= 1'b0;
			value_out <= '0;
		end else if (clk_en_in) begin
			values_ready_out <= next_ready;
			value_out <= next_ready ? values[value_select_in] : '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_start_mode(logic m);
		clk_en_in && start && word_mode == m;
	endsequence

	sequence s_idle_command;
		clk_en_in && control_valid_in && command == encoder_probe_pkg::CMD_NONE && !(|act);
	endsequence

	a_refmark_first_mark: assert property (@(posedge clk_in) disable iff (reset_in)
		(clk_en_in && mode == encoder_probe_pkg::MODE_REFMARK && act[0] && ref_rise && !(start && func_bits[0])
		&& mark_count == encoder_probe_pkg::MARK_COUNT_RESET) |=> dn[0] && !act[0])
		else $error("first reference mark did not complete function one");

	a_refmark_mode_set: assert property (@(posedge clk_in) disable iff (reset_in)
		s_start_mode(encoder_probe_pkg::MODE_REFMARK) |=> !mode_out && mark_count == 3'h0)
		else $error("reference mark search start not taken");

	a_probe_mode_set: assert property (@(posedge clk_in) disable iff (reset_in)
		s_start_mode(encoder_probe_pkg::MODE_PROBE) |=> mode_out)
		else $error("flying measurement start not taken");

	a_probe2_fall: assert property (@(posedge clk_in) disable iff (reset_in)
		(clk_en_in && mode == encoder_probe_pkg::MODE_PROBE && act[3] && probe2_last && !probe2_in
		&& !(start && func_bits[3]))
		|=> dn[3] && values[3] == $past(position_in))
		else $error("probe two falling edge not captured by function four");

	a_both_edges: assert property (@(posedge clk_in) disable iff (reset_in)
		(clk_en_in && start && word_mode && func_bits[1:0] == 2'h3) |=> act[0] && act[1])
		else $error("both edges of probe one not armed together");

	a_no_action: assert property (@(posedge clk_in) disable iff (reset_in)
		s_idle_command |=> !(|act))
		else $error("command 000 started a function");

	a_zero_bit_idle: assert property (@(posedge clk_in) disable iff (reset_in)
		(clk_en_in && start && !func_bits[2] && !act[2]) |=> !act[2])
		else $error("unrequested function was started");

	a_ready_gated: assert property (@(posedge clk_in) disable iff (reset_in)
		(clk_en_in && (|act)) |=> !values_ready_out ##0 value_out == '0)
		else $error("values readable while a function was active");

endmodule
`default_nettype wire

/* File: verification/controller_model.sv */
// Controller side model: presents control words as one-cycle telegrams.
// Assumes the bench calls send from its falling-edge driven sequence.
`timescale 1ns/100ps
`default_nettype none
module controller_model (
	input wire logic clk_in,
	output logic [encoder_probe_pkg::CTRL_WIDTH-1:0] encoder_control_word_out,
	output logic control_valid_out
);
	initial begin
		encoder_control_word_out = 16'h0000;
		control_valid_out = 1'b0;
	end

	// One telegram per call; zero bits request nothing
	task automatic send(input logic [encoder_probe_pkg::CTRL_WIDTH-1:0] word);
		@(negedge clk_in);
		encoder_control_word_out = word;
		control_valid_out = 1'b1;
		@(negedge clk_in);
		control_valid_out = 1'b0;
		encoder_control_word_out = ~word;
	endtask
endmodule
`default_nettype wire

/* File: verification/encoder_probe_refmark_control_bench.sv */
// Testbench for the encoder control word interpreter.
// Assumes controller_model supplies the telegrams; inputs change at falling edges.
`timescale 1ns/100ps
`default_nettype none
module encoder_probe_refmark_control_bench;
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic clk_en_in = 1'b1;
	logic ref_mark_in = 1'b0;
	logic probe1_in = 1'b0;
	logic probe2_in = 1'b0;
	logic [31:0] position_in = 32'h0;
	logic [1:0] value_select_in = 2'h0;
	logic [15:0] word;
	logic valid;
	logic [3:0] status;
	logic mode;
	logic ready;
	logic [31:0] value;
	int fail_count = 0;
	int checks_done = 0;

	always #5 clk_in = ~clk_in;

	controller_model i_ctrl (.clk_in(clk_in), .encoder_control_word_out(word), .control_valid_out(valid));

	encoder_probe_refmark_control #(.POS_WIDTH(32)) i_dut (
		.clk_in(clk_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
		.encoder_control_word_in(word), .control_valid_in(valid),
		.ref_mark_in(ref_mark_in), .probe1_in(probe1_in), .probe2_in(probe2_in),
		.position_in(position_in), .value_select_in(value_select_in),
		.function_status_bits_out(status), .mode_out(mode),
		.values_ready_out(ready), .value_out(value)
	);

	////////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic compare(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic check_status(input logic [3:0] exp);
		int n;
		n = 0;
		while (status !== exp && n < 20) begin
			@(negedge clk_in);
			n++;
		end
		compare({28'h0, status}, {28'h0, exp});
		if (status !== exp) end_of_test();
	endtask

	task automatic wait_ready();
		int n;
		n = 0;
		while (ready !== 1'b1 && n < 20) begin
			@(negedge clk_in);
			n++;
		end
		compare({31'h0, ready}, 32'h1);
		if (ready !== 1'b1) end_of_test();
	endtask

	task automatic check_value(input logic [1:0] sel, input logic [31:0] exp);
		value_select_in = sel;
		repeat (2) @(negedge clk_in);
		compare(value, exp);
	endtask

	task automatic pulse_ref(input logic [31:0] pos);
		@(negedge clk_in);
		position_in = pos;
		ref_mark_in = 1'b1;
		@(negedge clk_in);
		ref_mark_in = 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(negedge clk_in);
		reset_in = 1'b0;
		compare({26'h0, status, mode, ready}, 32'h0);
		compare(value, 32'h0);
		$display("test reset done");

		i_ctrl.send(16'h0011);
		check_status(4'h1);
		pulse_ref(32'h0000_1234);
		check_status(4'h0);
		wait_ready();
		check_value(2'h0, 32'h0000_1234);
		compare({31'h0, mode}, 32'h0);
		$display("test single mark done");

		i_ctrl.send(16'h0013);
		check_status(4'h3);
		@(negedge clk_in);
		probe1_in = 1'b1;
		repeat (3) @(negedge clk_in);
		compare({28'h0, status}, 32'h3);
		pulse_ref(32'h0000_0A01);
		check_status(4'h2);
		compare({31'h0, ready}, 32'h0);
		compare(value, 32'h0);
		pulse_ref(32'h0000_0B02);
		check_status(4'h0);
		wait_ready();
		check_value(2'h0, 32'h0000_0A01);
		check_value(2'h1, 32'h0000_0B02);
		probe1_in = 1'b0;
		$display("test two marks done");

		i_ctrl.send(16'h009F);
		check_status(4'hF);
		compare({31'h0, mode}, 32'h1);
		@(negedge clk_in);
		position_in = 32'h10;
		probe1_in = 1'b1;
		check_status(4'hE);
		@(negedge clk_in);
		position_in = 32'h20;
		probe1_in = 1'b0;
		check_status(4'hC);
		@(negedge clk_in);
		position_in = 32'h30;
		probe2_in = 1'b1;
		check_status(4'h8);
		@(negedge clk_in);
		position_in = 32'h40;
		probe2_in = 1'b0;
		check_status(4'h0);
		wait_ready();
		for (int s = 0; s < 4; s++) begin
			check_value(2'(s), 32'((s + 1) * 16));
		end
		$display("test probes done");

		for (int c = 0; c < 8; c++) begin
			if (c != 1) begin
				i_ctrl.send(16'h008F | 16'(c << 4));
				repeat (3) @(negedge clk_in);
				compare({28'h0, status}, 32'h0);
			end
		end
		i_ctrl.send(16'h0090);
		repeat (3) @(negedge clk_in);
		compare({28'h0, status}, 32'h0);
		compare({31'h0, ready}, 32'h1);
		$display("test refused done");

		clk_en_in = 1'b0;
		i_ctrl.send(16'h0011);
		repeat (3) @(negedge clk_in);
		compare({26'h0, status, mode, ready}, 32'h3);
		compare(value, 32'h0000_0040);
		clk_en_in = 1'b1;
		@(negedge clk_in);
		compare({26'h0, status, mode, ready}, 32'h3);
		$display("test clock enable done");

		reset_in = 1'b1;
		repeat (2) @(negedge clk_in);
		reset_in = 1'b0;
		compare({26'h0, status, mode, ready}, 32'h0);
		compare(value, 32'h0);
		$display("test second reset done");
		end_of_test();
	end
endmodule
`default_nettype wire
